/* design/oss_select.sv */
// Operand segment select: segment choice, overrides, 64-bit base rules and operand forms.
// Assumes decoder and address generation on ref_clk; one registered answer per request.
// Overview of operation
// - Fetches always use code segment.
// - Stack or frame base selects stack segment.
// - Other data references default to data segment.
// - String destination always uses extra segment.
// - Push and pop always use stack segment.
// - First-byte prefix overrides overridable data segment.
// - Explicit selector: 16 bits, memory or register.
// - Far pointer: offset doubleword then selector word.
// - Offsets 16/32 bits; 64 bits in long mode.
// - Long mode zeroes code/data/extra/stack bases.
// - Long mode keeps auxiliary segment bases.
// - Compatibility mode segments exactly like legacy.
// - Immediates allowed except divides; max doubleword.
// - Pair high half extension, low accumulator.
// - Extension prefix swaps high bytes for low bytes.
`timescale 1ns/1ps
`default_nettype none
module oss_select
    import oss_pkg::*;
(
    input wire logic ref_clk,                   // Core clock, 10 MHz
    input wire logic arst_n,                    // Asynchronous reset, active low
    input wire oss_req_t req,                   // Request from the decoder
    input wire logic [63:0] segBase [6],        // Segment bases indexed by oss_seg_t
    output oss_ans_t ans                        // Registered answer
);

    // Decode the override prefix byte; valid only for the six segment prefixes
    function automatic logic prefix_seg(input logic [7:0] b, output oss_seg_t s);
        s = OSS_SEG_DATA;
        prefix_seg = 1'b1;
        unique case (b)
            OSS_PFX_EXTRA: s = OSS_SEG_EXTRA;
            OSS_PFX_CODE:  s = OSS_SEG_CODE;
            OSS_PFX_STACK: s = OSS_SEG_STACK;
            OSS_PFX_DATA:  s = OSS_SEG_DATA;
            OSS_PFX_AUXF:  s = OSS_SEG_AUXF;
            OSS_PFX_AUXG:  s = OSS_SEG_AUXG;
            default:       prefix_seg = 1'b0;
        endcase
    endfunction

    // Truncate an offset to the address size in force
    function automatic logic [63:0] size_offset(input logic [63:0] ea, input oss_asz_t a, input oss_mode_t m);
        size_offset = {{(64 - OSS_OFS32_W){1'b0}}, ea[OSS_OFS32_W-1:0]};
        if (a == OSS_ASZ_16) begin
            size_offset = {{(64 - OSS_OFS16_W){1'b0}}, ea[OSS_OFS16_W-1:0]};
        end else if (a == OSS_ASZ_64 && m == OSS_MODE_LONG) begin
            size_offset = ea;
        end
    endfunction

    oss_seg_t next_seg;
    logic [63:0] next_lin;
    logic [63:0] offs;
    oss_seg_t pfxSeg;
    logic pfxHit;
    logic stackBase;
    logic bytesIllegal;

    // Segment choice; fixed references never look at the prefix
    always_comb begin
        pfxHit = prefix_seg(req.firstByte, pfxSeg);
        stackBase = req.hasBase && (req.baseReg == OSS_GPR_STACKPTR || req.baseReg == OSS_GPR_FRAME);
        unique case (req.refKind)
            OSS_REF_FETCH:   next_seg = OSS_SEG_CODE;
            OSS_REF_PUSHPOP: next_seg = OSS_SEG_STACK;
            OSS_REF_STRDST:  next_seg = OSS_SEG_EXTRA;
            default: begin
                // Compatibility mode takes the same path as legacy here
                if (pfxHit) begin
                    next_seg = pfxSeg;
                end else if (stackBase) begin
                    next_seg = OSS_SEG_STACK;
                end else begin
                    next_seg = OSS_SEG_DATA;
                end
            end
        endcase
    end

    // Linear address; long mode drops the four flat bases only
    always_comb begin
        offs = size_offset(req.effAddr, req.asz, req.mode);
        if (req.mode == OSS_MODE_LONG && next_seg != OSS_SEG_AUXF && next_seg != OSS_SEG_AUXG) begin
            next_lin = offs;
        end else begin
            next_lin = offs + segBase[next_seg];
        end
    end

    // Byte register legality: numbers above 7 are legal only with the extension prefix in long mode
    always_comb begin
        bytesIllegal = 1'b0;
        if (req.byteReg && req.mode == OSS_MODE_LONG) begin
            if (req.extPrefix) begin
                bytesIllegal = 1'b0;
            end else begin
                bytesIllegal = req.byteRegNum > 4'h7;
            end
        end else if (req.byteReg) begin
            bytesIllegal = req.byteRegNum > 4'h7;
        end
    end

    // Segment and address part of the answer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ans.valid <= 1'b0;
            ans.seg <= OSS_SEG_DATA;
            ans.linAddr <= 64'h0;
        end else begin
            ans.valid <= req.valid;
            ans.seg <= next_seg;
            ans.linAddr <= next_lin;
        end
    end

    // Operand form part of the answer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ans.immIllegal <= 1'b0;
            ans.pairAcc <= 32'h0;
            ans.pairDext <= 32'h0;
            ans.farOffset <= 32'h0;
            ans.selector <= 16'h0;
            ans.byteIllegal <= 1'b0;
            ans.byteHigh <= 1'b0;
        end else begin
            ans.immIllegal <= req.immUsed && (req.arith != OSS_ARITH_OTHER || req.immValue > OSS_IMM_MAX);
            ans.pairAcc <= req.pairUsed ? req.pairValue[31:0] : 32'h0;
            ans.pairDext <= req.pairUsed ? req.pairValue[63:32] : 32'h0;
            ans.farOffset <= req.farPtr ? req.farMem[31:0] : 32'h0;
            if (req.farPtr) begin
                ans.selector <= req.farMem[47:32];
            end else begin
                ans.selector <= req.selFromReg ? req.selReg : req.selMem;
            end
            ans.byteIllegal <= bytesIllegal;
            ans.byteHigh <= req.byteReg && !req.extPrefix && req.byteRegNum[2:0] >= OSS_HIGH_BYTE_FIRST
                            && req.byteRegNum[3] == 1'b0;
        end
    end

    // Checks beside the logic
    property p_fetch_code;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_FETCH |=> ans.seg == OSS_SEG_CODE;
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("fetch not on code segment");

    property p_stack_base;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_DATA && stackBase && !pfxHit |=> ans.seg == OSS_SEG_STACK;
    endproperty
    a_stack_base: assert property (p_stack_base) else $error("stack base not on stack segment");

    property p_data_default;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_DATA && !stackBase && !pfxHit |=> ans.seg == OSS_SEG_DATA;
    endproperty
    a_data_default: assert property (p_data_default) else $error("data default wrong");

    property p_strdst;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_STRDST |=> ans.seg == OSS_SEG_EXTRA;
    endproperty
    a_strdst: assert property (p_strdst) else $error("string destination not on extra segment");

    property p_pushpop;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_PUSHPOP |=> ans.seg == OSS_SEG_STACK;
    endproperty
    a_pushpop: assert property (p_pushpop) else $error("push or pop not on stack segment");

    property p_override;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.refKind == OSS_REF_DATA && req.firstByte == OSS_PFX_AUXG |=> ans.seg == OSS_SEG_AUXG;
    endproperty
    a_override: assert property (p_override) else $error("override prefix not applied");

    property p_flat;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.mode == OSS_MODE_LONG && req.asz == OSS_ASZ_64 && req.refKind == OSS_REF_FETCH
        |=> ans.linAddr == $past(req.effAddr);
    endproperty
    a_flat: assert property (p_flat) else $error("long mode base not zero");

    property p_pair;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.pairUsed |=> {ans.pairDext, ans.pairAcc} == $past(req.pairValue);
    endproperty
    a_pair: assert property (p_pair) else $error("register pair halves swapped");

    property p_div_imm;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.immUsed && req.arith == OSS_ARITH_SDIV |=> ans.immIllegal;
    endproperty
    a_div_imm: assert property (p_div_imm) else $error("divide immediate accepted");

    property p_imm_ok;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.immUsed && req.arith == OSS_ARITH_OTHER && req.immValue <= OSS_IMM_MAX |=> !ans.immIllegal;
    endproperty
    a_imm_ok: assert property (p_imm_ok) else $error("legal immediate refused");

    property p_aux_long;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.mode == OSS_MODE_LONG && req.asz == OSS_ASZ_64 && req.refKind == OSS_REF_DATA
        && req.firstByte == OSS_PFX_AUXF |=> ans.linAddr == $past(req.effAddr + segBase[OSS_SEG_AUXF]);
    endproperty
    a_aux_long: assert property (p_aux_long) else $error("auxiliary base dropped in long mode");

    property p_far;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.farPtr |=> ans.farOffset == $past(req.farMem[31:0]) && ans.selector == $past(req.farMem[47:32]);
    endproperty
    a_far: assert property (p_far) else $error("far pointer split wrong");

    property p_byte_ext;
        @(posedge ref_clk) disable iff (!arst_n)
        req.valid && req.byteReg && req.mode == OSS_MODE_LONG && req.extPrefix |=> !ans.byteHigh && !ans.byteIllegal;
    endproperty
    a_byte_ext: assert property (p_byte_ext) else $error("byte register wrong with extension prefix");

endmodule // oss_select
`default_nettype wire

/* design/oss_pkg.sv */
// Package for the operand segment select block: segment codes, reference kinds,
// operand forms and the request/answer structs shared with the decoder.
// Assumes one core clock domain and a decoder that presents one request per cycle.
package oss_pkg;

    // Segment register codes, also the override prefix field encoding
    typedef enum logic [2:0] {
        OSS_SEG_EXTRA = 3'h0,
        OSS_SEG_CODE  = 3'h1,
        OSS_SEG_STACK = 3'h2,
        OSS_SEG_DATA  = 3'h3,
        OSS_SEG_AUXF  = 3'h4,
        OSS_SEG_AUXG  = 3'h5
    } oss_seg_t;

    // Reference kinds presented by the decoder
    typedef enum logic [2:0] {
        OSS_REF_FETCH   = 3'h0,
        OSS_REF_DATA    = 3'h1,
        OSS_REF_PUSHPOP = 3'h2,
        OSS_REF_STRDST  = 3'h3,
        OSS_REF_STRSRC  = 3'h4
    } oss_ref_t;

    // Operating modes
    typedef enum logic [1:0] {
        OSS_MODE_LEGACY = 2'h0,
        OSS_MODE_COMPAT = 2'h1,
        OSS_MODE_LONG   = 2'h2
    } oss_mode_t;

    // Address sizes
    typedef enum logic [1:0] {
        OSS_ASZ_16 = 2'h0,
        OSS_ASZ_32 = 2'h1,
        OSS_ASZ_64 = 2'h2
    } oss_asz_t;

    // General register numbers, first high-byte register, offset and selector widths, immediate limit
    localparam logic [3:0] OSS_GPR_ACC = 4'h0;
    localparam logic [3:0] OSS_GPR_DEXT = 4'h2;
    localparam logic [3:0] OSS_GPR_STACKPTR = 4'h4;
    localparam logic [3:0] OSS_GPR_FRAME = 4'h5;
    localparam logic [2:0] OSS_HIGH_BYTE_FIRST = 3'h4;
    localparam int OSS_OFS16_W = 16;
    localparam int OSS_OFS32_W = 32;
    localparam int OSS_SEL_W = 16;
    localparam logic [63:0] OSS_IMM_MAX = 64'h0000_0000_ffff_ffff;

    // Segment-override prefix bytes
    localparam logic [7:0] OSS_PFX_EXTRA = 8'h26;
    localparam logic [7:0] OSS_PFX_CODE = 8'h2e;
    localparam logic [7:0] OSS_PFX_STACK = 8'h36;
    localparam logic [7:0] OSS_PFX_DATA = 8'h3e;
    localparam logic [7:0] OSS_PFX_AUXF = 8'h64;
    localparam logic [7:0] OSS_PFX_AUXG = 8'h65;

    // Arithmetic opcode classes for the immediate check
    typedef enum logic [1:0] {
        OSS_ARITH_OTHER = 2'h0,
        OSS_ARITH_UDIV  = 2'h1,
        OSS_ARITH_SDIV  = 2'h2
    } oss_arith_t;

    // Request from decoder
    typedef struct packed {
        logic       valid;
        oss_mode_t  mode;
        oss_asz_t   asz;
        oss_ref_t   refKind;
        logic       hasBase;
        logic [3:0] baseReg;
        logic [7:0] firstByte;    // first byte of the instruction
        logic [63:0] effAddr;     // effective address from address generation
        logic       immUsed;
        oss_arith_t arith;
        logic [63:0] immValue;
        logic       pairUsed;
        logic [63:0] pairValue;   // quadword to split over the register pair
        logic       farPtr;
        logic [47:0] farMem;      // 48-bit far pointer image, lowest byte first
        logic       selFromReg;
        logic [15:0] selReg;
        logic [15:0] selMem;
        logic       byteReg;
        logic       extPrefix;
        logic [3:0] byteRegNum;
    } oss_req_t;

    // Answer to address generation
    typedef struct packed {
        logic       valid;
        oss_seg_t   seg;
        logic [63:0] linAddr;
        logic       immIllegal;
        logic [31:0] pairAcc;
        logic [31:0] pairDext;
        logic [31:0] farOffset;
        logic [15:0] selector;
        logic       byteIllegal;
        logic       byteHigh;     // names a legacy high-byte register
    } oss_ans_t;

endpackage : oss_pkg

/* test/oss_agen_model.sv */
// Address-generation stand-in: holds the six segment bases for the selector.
// Assumes the bench raises reload only while no request is in flight.
`timescale 1ns/1ps
`default_nettype none
module oss_agen_model
    import oss_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic reload, // Pick fresh bases
    output logic [63:0] segBase [6] // Bases by segment code
);
    // Bases stay below 2^31 so a legacy sum always stays below 2^33
    always_ff @(posedge ref_clk) begin
        if (reload) begin
            for (int i = 0; i < 6; i++) begin
                segBase[i] <= {33'h0, 31'($urandom)};
            end
        end
    end
endmodule // oss_agen_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the operand segment selector.
// Assumes one registered answer, exactly one cycle after each valid request.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import oss_pkg::*;
    localparam logic [7:0] PFX [6] = '{OSS_PFX_EXTRA, OSS_PFX_CODE, OSS_PFX_STACK,
        OSS_PFX_DATA, OSS_PFX_AUXF, OSS_PFX_AUXG};
    logic refClk = 1'b0;
    logic arstN = 1'b0;
    logic reload = 1'b1;
    oss_req_t req = '0;
    oss_ans_t ans;
    oss_ans_t e;
    logic [63:0] segBase [6];
    oss_ans_t expQ [$];
    int cycQ [$];
    logic farQ [$];
    int cyc = 0;
    int errors = 0;
    int nCompared = 0;

    oss_select i_dut (.ref_clk(refClk), .arst_n(arstN), .req(req), .segBase(segBase), .ans(ans));
    oss_agen_model i_agen (.ref_clk(refClk), .reload(reload), .segBase(segBase));

    // Clock and cycle count
    always #50 refClk = ~refClk;
    always @(posedge refClk) cyc <= cyc + 1;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, errors %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reference answer, worked out at send time from the bases then held
    function automatic oss_ans_t predict(oss_req_t r);
        oss_ans_t a;
        logic [63:0] ofs;
        a = '0;
        a.valid = 1'b1;
        case (r.refKind)
            OSS_REF_FETCH: a.seg = OSS_SEG_CODE;
            OSS_REF_PUSHPOP: a.seg = OSS_SEG_STACK;
            OSS_REF_STRDST: a.seg = OSS_SEG_EXTRA;
            default: begin
                a.seg = OSS_SEG_DATA;
                if (r.hasBase && r.baseReg inside {OSS_GPR_STACKPTR, OSS_GPR_FRAME}) a.seg = OSS_SEG_STACK;
                for (int i = 0; i < 6; i++) if (r.firstByte == PFX[i]) a.seg = oss_seg_t'(i);
            end
        endcase
        ofs = (r.asz == OSS_ASZ_16) ? {48'h0, r.effAddr[15:0]} : {32'h0, r.effAddr[31:0]};
        if (r.asz == OSS_ASZ_64) ofs = r.effAddr;
        a.linAddr = ofs;
        if (r.mode != OSS_MODE_LONG || a.seg inside {OSS_SEG_AUXF, OSS_SEG_AUXG}) a.linAddr = ofs + segBase[a.seg];
        a.immIllegal = r.arith != OSS_ARITH_OTHER || r.immValue > OSS_IMM_MAX;
        a.pairAcc = r.pairValue[31:0];
        a.pairDext = r.pairValue[63:32];
        a.farOffset = r.farMem[31:0];
        a.selector = r.farPtr ? r.farMem[47:32] : (r.selFromReg ? r.selReg : r.selMem);
        a.byteHigh = !r.extPrefix && r.byteRegNum inside {[4:7]};
        // Outside long mode the extension prefix does not exist, so numbers above 7 stay illegal
        a.byteIllegal = r.byteRegNum > 7 && (r.mode != OSS_MODE_LONG || !r.extPrefix);
        return a;
    endfunction

    // Random request; 64-bit offsets only in long mode, immediates near the limit
    function automatic oss_req_t rand_req(input int m);
        logic [$bits(oss_req_t)-1:0] v;
        oss_req_t r;
        for (int i = 0; i < $bits(v); i += 32) v = {v[$bits(v)-33:0], $urandom};
        r = oss_req_t'(v);
        r.valid = 1'b1;
        r.mode = oss_mode_t'(m);
        r.asz = oss_asz_t'($urandom_range(m == 2 ? 2 : 1));
        r.refKind = oss_ref_t'($urandom_range(4));
        r.arith = oss_arith_t'($urandom_range(2));
        r.baseReg = 4'($urandom_range(7));
        r.immUsed = 1'b1;
        r.pairUsed = 1'b1;
        r.byteReg = 1'b1;
        case ($urandom_range(3))
            0: r.immValue = OSS_IMM_MAX;
            1: r.immValue = OSS_IMM_MAX + 64'h1;
            2: r.immValue = {32'h0, $urandom};
            default: ;
        endcase
        if ($urandom_range(1)) r.firstByte = PFX[$urandom_range(5)];
        return r;
    endfunction

    task automatic send(input oss_req_t r);
        @(negedge refClk);
        req = r;
        if (r.valid) begin
            expQ.push_back(predict(r));
            cycQ.push_back(cyc);
            farQ.push_back(r.farPtr);
        end
    endtask

    // Watcher: each answer is matched against the oldest note
    always @(posedge refClk) begin
        #1;
        if (arstN && ans.valid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(64'h1, 64'h0); // unexpected answer
            end else begin
                e = expQ.pop_front();
                check(64'(cyc), 64'(cycQ.pop_front() + 1)); // answer one cycle later
                check(64'(ans.seg), 64'(e.seg));
                check(ans.linAddr, e.linAddr);
                check(64'(ans.immIllegal), 64'(e.immIllegal));
                check({ans.pairDext, ans.pairAcc}, {e.pairDext, e.pairAcc});
                if (farQ.pop_front()) check(64'(ans.farOffset), 64'(e.farOffset));
                check(64'(ans.selector), 64'(e.selector));
                check({ans.byteHigh, ans.byteIllegal}, {e.byteHigh, e.byteIllegal});
            end
        end else if (cycQ.size() > 0 && cyc > cycQ[0] + 1) begin
            check(64'h0, 64'h1); // missing answer
            void'(expQ.pop_front());
            void'(cycQ.pop_front());
            void'(farQ.pop_front());
        end
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge refClk) begin
        if (cyc >= 2000) begin
            errors++;
            conclude();
        end
    end

    // Main sequence: sweep of kind, prefix and mode, then random traffic
    initial begin
        oss_req_t r;
        void'($urandom(4970));
        repeat (20) @(posedge refClk);
        @(negedge refClk);
        arstN = 1'b1;
        reload = 1'b0;
        for (int k = 0; k < 5; k++) begin
            for (int p = 0; p < 7; p++) begin
                for (int m = 0; m < 3; m++) begin
                    r = rand_req(m);
                    r.refKind = oss_ref_t'(k);
                    r.firstByte = (p < 6) ? PFX[p] : 8'h90;
                    send(r);
                end
            end
        end
        send('0);
        send('0);
        reload = 1'b1;
        send('0);
        reload = 1'b0;
        for (int n = 0; n < 300; n++) begin
            r = rand_req($urandom_range(2));
            r.valid = ($urandom_range(3) != 0);
            send(r);
        end
        send('0);
        send('0);
        // Reset in mid-run: answer cleared, segment parked on data
        arstN = 1'b0;
        #10;
        check({ans.valid, 60'h0, ans.seg}, {1'b0, 60'h0, OSS_SEG_DATA});
        send('0);
        arstN = 1'b1;
        for (int n = 0; n < 20; n++) send(rand_req(2));
        send('0);
        send('0);
        conclude();
    end
endmodule // testbench
`default_nettype wire
